/* File: plli_pkg.sv */
package plli_pkg;

  localparam int unsigned num_ports = 8;
  localparam int unsigned clk_freq_hz = 100000000;
  // blink half period in milliseconds, as printed
  localparam int unsigned blink_half_ms = 84;
  localparam longint unsigned blink_half_cycles_l =
    (longint'(blink_half_ms) * longint'(clk_freq_hz)) / 64'd1000;
  localparam int unsigned blink_half_cycles = int'(blink_half_cycles_l);

  // reset values
  localparam logic led_off = 1'b1;
  localparam logic mode_rst = 1'b0;
  // last wait count before the strap is taken: two sync stages plus one settle edge
  localparam logic [1:0] strap_wait_last = 2'h2;

  // port mode, taken from the strap once after reset
  typedef enum logic {
    plli_mode_copper,
    plli_mode_fiber
  } plli_mode_t;

  // per-port status coming from the mac/phy side (same clock domain)
  typedef struct packed {
    logic link_up;
    logic speed_100;
    logic activity;
  } plli_port_status_t;

endpackage : plli_pkg

/* File: plli_top.sv */
module plli_top #(
  parameter int unsigned num_ports = plli_pkg::num_ports,
  parameter int unsigned blink_half_cycles = plli_pkg::blink_half_cycles
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire plli_pkg::plli_port_status_t [num_ports-1:0] port_status,
  input wire logic [num_ports-1:0] fiber_signal_detect_in,
  input wire logic [num_ports-1:0] mode_strap,
  output logic [num_ports-1:0] port_link_up,
  output logic [num_ports-1:0] port_fiber_mode,
  output logic [num_ports-1:0] link_activity_led_n,
  output logic [num_ports-1:0] port_a
);

  // the blink counter needs at least one state per half, the vectors at least one port
  if (num_ports < 1) begin : g_bad_ports
    $error("plli_top: num_ports must be at least 1");
  end
  if (blink_half_cycles < 1) begin : g_bad_half
    $error("plli_top: blink_half_cycles must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage is read only by the second

  logic [num_ports-1:0] sd_s1, sd_s2, next_sd_s1, next_sd_s2;
  logic [num_ports-1:0] st_s1, st_s2, next_st_s1, next_st_s2;

  always_comb begin
    next_sd_s1 = sd_s1;
    next_sd_s2 = sd_s2;
    next_st_s1 = st_s1;
    next_st_s2 = st_s2;
    if (clk_en) begin
      next_sd_s1 = fiber_signal_detect_in;
      next_sd_s2 = sd_s1;
      next_st_s1 = mode_strap;
      next_st_s2 = st_s1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sd_s1 <= '0;
      sd_s2 <= '0;
      st_s1 <= '0;
      st_s2 <= '0;
    end else begin
      sd_s1 <= next_sd_s1;
      sd_s2 <= next_sd_s2;
      st_s1 <= next_st_s1;
      st_s2 <= next_st_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap capture: waits for the synchroniser to fill after release

  logic [1:0] strap_wait, next_strap_wait;
  logic strap_done, next_strap_done;
  plli_pkg::plli_mode_t [num_ports-1:0] mode, next_mode;

  always_comb begin
    next_strap_wait = strap_wait;
    next_strap_done = strap_done;
    next_mode = mode;
    if (clk_en && !strap_done) begin
      if (strap_wait == plli_pkg::strap_wait_last) begin
        next_strap_done = 1'b1;
        for (int i = 0; i < num_ports; i++) begin
          next_mode[i] = st_s2[i] ? plli_pkg::plli_mode_fiber
                                  : plli_pkg::plli_mode_copper;
        end
      end else begin
        next_strap_wait = strap_wait + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      strap_wait <= 2'h0;
      strap_done <= 1'b0;
      mode <= '{default: plli_pkg::plli_mode_copper};
    end else begin
      strap_wait <= next_strap_wait;
      strap_done <= next_strap_done;
      mode <= next_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-port link qualification, link register and speed led register

  logic [num_ports-1:0] link_q;
  logic [num_ports-1:0] spd_led, next_spd_led;
  logic [num_ports-1:0] link_reg, next_link_reg;
  logic [num_ports-1:0] blink_led_n;

  always_comb begin
    for (int i = 0; i < num_ports; i++) begin
      // fiber needs light as well as mac link; copper takes the mac alone
      if (mode[i] == plli_pkg::plli_mode_fiber) begin
        link_q[i] = port_status[i].link_up & sd_s2[i];
      end else begin
        link_q[i] = port_status[i].link_up;
      end
    end
  end

  always_comb begin
    next_spd_led = spd_led;
    next_link_reg = link_reg;
    if (clk_en) begin
      next_link_reg = link_q;
      for (int i = 0; i < num_ports; i++) begin
        next_spd_led[i] = ~port_status[i].speed_100;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      spd_led <= {num_ports{plli_pkg::led_off}};
      link_reg <= '0;
    end else begin
      spd_led <= next_spd_led;
      link_reg <= next_link_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one blink timer per port, so a busy port never disturbs its neighbours

  for (genvar g = 0; g < num_ports; g++) begin : g_port
    plli_blink #(
      .blink_half_cycles(blink_half_cycles)
    ) u_blink (
      .mclk(mclk),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .link(link_q[g]),
      .activity(port_status[g].activity),
      .led_n(blink_led_n[g])
    );
  end

  always_comb begin
    for (int i = 0; i < num_ports; i++) begin
      port_fiber_mode[i] = (mode[i] == plli_pkg::plli_mode_fiber);
    end
  end

  assign link_activity_led_n = blink_led_n;
  assign port_a = spd_led;
  assign port_link_up = link_reg;

endmodule // plli_top

////////////////////////////////////////////////////////////////////////////
// single-port blink timer; the led output comes straight from a flop

module plli_blink #(
  parameter int unsigned blink_half_cycles = plli_pkg::blink_half_cycles
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic link,
  input wire logic activity,
  output logic led_n
);

  localparam int unsigned cnt_w = $clog2(blink_half_cycles + 1);

  if (blink_half_cycles < 1) begin : g_bad_half
    $error("plli_blink: blink_half_cycles must be at least 1");
  end

  logic phase, next_phase;
  logic act_led, next_act_led;
  logic [cnt_w-1:0] cnt, next_cnt;

  always_comb begin
    next_phase = phase;
    next_cnt = cnt;
    next_act_led = act_led;
    if (clk_en) begin
      if (!link) begin
        // timer parked so the next burst starts with a full lit half
        next_cnt = '0;
        next_phase = 1'b0;
        next_act_led = plli_pkg::led_off;
      end else if (activity || phase || cnt != '0) begin
        // a started cycle completes unless the link drops, so short bursts stay visible
        if (cnt == cnt_w'(blink_half_cycles - 1)) begin
          next_cnt = '0;
          next_phase = ~phase;
        end else begin
          next_cnt = cnt + cnt_w'(1);
        end
        next_act_led = next_phase;
      end else begin
        next_act_led = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= 1'b0;
      cnt <= '0;
      act_led <= plli_pkg::led_off;
    end else begin
      phase <= next_phase;
      cnt <= next_cnt;
      act_led <= next_act_led;
    end
  end

  assign led_n = act_led;

endmodule // plli_blink

/* File: plli_top_assertions.sv */
module plli_chk #(
  parameter int unsigned num_ports = 8,
  parameter int unsigned blink_half_cycles = 8
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire plli_pkg::plli_port_status_t [num_ports-1:0] port_status,
  input wire logic [num_ports-1:0] fiber_signal_detect_in,
  input wire logic [num_ports-1:0] mode_strap,
  input wire logic [num_ports-1:0] port_link_up,
  input wire logic [num_ports-1:0] port_fiber_mode,
  input wire logic [num_ports-1:0] link_activity_led_n,
  input wire logic [num_ports-1:0] port_a
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // four samples cover the two sync flops plus the link register
  property p_fib; (clk_en && port_fiber_mode[4] && !fiber_signal_detect_in[4])[*4] |=> !port_link_up[4]; endproperty
  a_fib: assert property (p_fib) else $error("fiber link without light");
  property p_cu; clk_en && !port_fiber_mode[0] && port_status[0].link_up |=> port_link_up[0]; endproperty
  a_cu: assert property (p_cu) else $error("copper link lost");
  property p_dn; clk_en && !port_status[0].link_up |=> link_activity_led_n[0]; endproperty
  a_dn: assert property (p_dn) else $error("led lit with link down");
  property p_on; $rose(link_activity_led_n[0]) && port_link_up[0] |-> !$past(link_activity_led_n[0], blink_half_cycles); endproperty
  a_on: assert property (p_on) else $error("lit phase too short");
  property p_off; $fell(link_activity_led_n[0]) && $past(port_link_up[0]) |-> $past(link_activity_led_n[0], blink_half_cycles); endproperty
  a_off: assert property (p_off) else $error("dark phase too short");
  property p_spd; clk_en |=> port_a[0] == !$past(port_status[0].speed_100); endproperty
  a_spd: assert property (p_spd) else $error("port_a wrong");
  property p_mode; $changed(port_fiber_mode) |-> ($past(port_fiber_mode) & ~port_fiber_mode) == '0; endproperty
  a_mode: assert property (p_mode) else $error("mode left fiber");
  property p_stdy; (~port_link_up & ~link_activity_led_n) == '0; endproperty
  a_stdy: assert property (p_stdy) else $error("led lit on a dead port");
endmodule // plli_chk
bind plli_top plli_chk #(.num_ports(num_ports), .blink_half_cycles(blink_half_cycles)) u_chk (.*);

/* File: plli_xcvr.sv */
module plli_xcvr (
  input wire logic [7:0] light,
  output logic [7:0] sd
);
  // sd follows light directly, so a dark transceiver reads low
  assign sd = light;
endmodule // plli_xcvr

/* File: test_port_link_led_indicator.sv */
module test_port_link_led_indicator;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned nh = 6;
  logic mclk = 1'b0, arst_n = 1'b0, clk_en = 1'b1;
  logic [7:0] lk = 8'h00, sp = 8'h00, ac = 8'h00, light = 8'h00, mode_strap = 8'hf0;
  logic [7:0] fiber_signal_detect_in, port_link_up, port_fiber_mode, link_activity_led_n, port_a;
  plli_pkg::plli_port_status_t [7:0] port_status;
  int n_fail = 0, num_checks = 0;
  always #5 mclk = ~mclk;
  always_comb for (int i = 0; i < 8; i++) port_status[i] = '{lk[i], sp[i], ac[i]};
  plli_xcvr xcvr (.light(light), .sd(fiber_signal_detect_in));
  plli_top #(.blink_half_cycles(nh)) DUT (.*);
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic close_out;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_link;
    lk = 8'hff;
    sp = 8'h55;
    light = 8'h30;
    step(5);
    chk("link", 8'h3f, port_link_up);
    chk("led", 8'hc0, link_activity_led_n);
    chk("speed", 8'haa, port_a);
    mode_strap = 8'h0f;
    step(5);
    chk("mode", 8'hf0, port_fiber_mode);
    $display("t_link done");
  endtask
  task automatic t_blink;
    logic [7:0] h;
    h = 8'h00;
    ac = 8'h01;
    step(1);
    ac = 8'h00;
    // count dark cycles rather than edges, so the phase start may shift by one
    for (int i = 0; i < 3 * nh; i++) begin
      step(1);
      h += {7'h00, link_activity_led_n[0]};
    end
    chk("dark", 8'(nh), h);
    chk("after", 8'hc0, link_activity_led_n);
    $display("t_blink done");
  endtask
  task automatic t_down;
    lk = 8'hfe;
    light = 8'h20;
    step(5);
    chk("ledd", 8'hd1, link_activity_led_n);
    chk("linkd", 8'h2e, port_link_up);
    $display("t_down done");
  endtask
  task automatic t_hold;
    clk_en = 1'b0;
    lk = 8'h00;
    sp = 8'hff;
    step(3);
    chk("hold_link", 8'h2e, port_link_up);
    chk("hold_speed", 8'haa, port_a);
    clk_en = 1'b1;
    step(1);
    chk("run_link", 8'h00, port_link_up);
    chk("run_led", 8'hff, link_activity_led_n);
    chk("run_speed", 8'h00, port_a);
    $display("t_hold done");
  endtask
  initial begin
    step(1);
    chk("rst", 8'hff, link_activity_led_n & port_a);
    step(2);
    arst_n = 1'b1;
    step(4);
    t_link();
    t_blink();
    t_down();
    t_hold();
    close_out();
  end
  initial begin
    #20us;
    n_fail++;
    close_out();
  end
endmodule // test_port_link_led_indicator
